// ==== spf_consts.vh ====
// Constants for the self-programming flash controller.
// Assumes inclusion by bare name from a design file that uses them.
`ifndef SPF_CONSTS_VH
`define SPF_CONSTS_VH
// ========================================
// Register map
// The control register keeps its 0x37 index; its bus word sits at four times that.
`define SPF_IDX_CSR         8'h37
`define SPF_ADDR_CSR        {22'h0, `SPF_IDX_CSR, 2'b00}
`define SPF_ADDR_CTRL       32'h0000_0040
`define SPF_ADDR_ZPTR       32'h0000_0044
`define SPF_ADDR_DATA       32'h0000_0048
`define SPF_ADDR_CMD        32'h0000_004C
`define SPF_ADDR_LPMDATA    32'h0000_0050
`define SPF_ADDR_STAT       32'h0000_0054
`define SPF_ADDR_LOCKFUSE   32'h0000_0058
`define SPF_CSR_RESET       8'h00
// ========================================
// Control and status bit positions
`define SPF_B_IE            7
`define SPF_B_BUSY          6
`define SPF_B_RES           5
`define SPF_B_REEN          4
`define SPF_B_LOCK          3
`define SPF_B_PGWR          2
`define SPF_B_PGER          1
`define SPF_B_EN            0
// ========================================
// Accepted lower-five-bit patterns
`define SPF_PAT_REEN        5'h11
`define SPF_PAT_LOCK        5'h09
`define SPF_PAT_PGWR        5'h05
`define SPF_PAT_PGER        5'h03
`define SPF_PAT_FILL        5'h01
// ========================================
// Flash geometry
`define SPF_PAGE_WORDS      64
`define SPF_STALLED_DURING_WRITE_AREA_START      13'h1C00
`define SPF_BOOT_128        13'h1F80
`define SPF_BOOT_256        13'h1F00
`define SPF_BOOT_512        13'h1E00
`define SPF_BOOT_1024       13'h1C00
`define SPF_BOOT_END        13'h1FFF
// ========================================
// Timing: 10 MHz core clock
`define SPF_CLK_HZ          10000000
`define SPF_WINDOW_SPM      3'd4
`define SPF_WINDOW_LPM      3'd3
`define SPF_PROG_MIN_US     3700
`define SPF_PROG_MAX_US     4500
`define SPF_PROG_CYC        ((`SPF_PROG_MIN_US * (`SPF_CLK_HZ / 1000000)))
`define SPF_CMD_SPM         2'd1
`define SPF_CMD_LPM         2'd2
`endif

// ==== spf_self_program_flash_control.v ====
// Self-programming flash controller: control register, arming window, page buffer,
// page erase/write timing, lock-bit write and readback, section busy tracking.
// Assumes an AHB-Lite master with single word transfers standing in for the core.
// How it works
// R1 - Boot size bits choose boot start 1F80, 1F00, 1E00 or 1C00, ending 1FFF.
// R2 - Words below 1C00 are readable while writing; 1C00 to 1FFF are not.
// R3 - Pages hold 64 words; page number comes from pointer bits 13 to 7.
// R4 - Software places word index in pointer bits 6 to 1, zero for page write.
// R5 - Pointer bits 15 and 14 are ignored; bit 0 selects byte on reads.
// R6 - Eight-bit control and status register at 0x37, reset to zero.
// R7 - Ready interrupt requested while enable bit 7, global enable set, enable clear.
// R8 - Busy flag bit 6 set when erase or write to readable area starts.
// R9 - Busy flag cleared by re-enable after completion or by buffer load.
// R10 - Reserved bit 5 always reads zero.
// R11 - Re-enable needs enable bit clear first; refused while operation is busy.
// R12 - Re-enable written during buffer loading discards the loaded buffer.
// R13 - Lock-set with enable then store programs lock bits from R0.
// R14 - Lock-set clears when lock write completes or the window expires.
// R15 - Load within three cycles of lock arming returns lock or fuse bits.
// R16 - Page-write with enable then store writes buffer into addressed page.
// R17 - Page-write bit clears on completion or on window expiry.
// R18 - Core stalled through erase or write aimed at the unreadable area.
// R19 - Page-erase with enable then store erases page; clears on end or timeout.
// R20 - Enable alone then store puts R1:R0 into buffer word at pointer.
// R21 - Enable arms four cycles, clears after store; held during erase or write.
// R22 - Only patterns 10001, 01001, 00101, 00011, 00001 take effect.
// R23 - Erase, write and lock write each take between 3.7 and 4.5 ms.
// R24 - Arming window counter started on write clears enable and commands on expiry.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "spf_consts.vh"
module spf_self_program_flash_control #(
  parameter [31:0] PROG_CYCLES = `SPF_PROG_CYC
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Fuses and global interrupt enable
  input  wire        boot_size_hi,
  input  wire        boot_size_lo,
  input  wire        global_irq_enable,
  input  wire [7:0]  fuse_bits,
  // Status toward the core
  output wire        program_ready_irq,
  output wire        core_stall,
  output wire [12:0] boot_start,
  output wire        section_block
);
  // ========================================
  // Bus address phase capture
  reg        ap_valid;
  reg        ap_write;
  reg [31:0] ap_addr;
  wire       ap_take = hsel && hready && htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 32'h0000_0000;
    end else if (hready) begin
      ap_valid <= ap_take;
      ap_write <= hwrite;
      ap_addr  <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  wire wr_csr  = ap_valid && ap_write && (ap_addr == `SPF_ADDR_CSR);
  wire wr_ctrl = ap_valid && ap_write && (ap_addr == `SPF_ADDR_CTRL);
  wire wr_zptr = ap_valid && ap_write && (ap_addr == `SPF_ADDR_ZPTR);
  wire wr_data = ap_valid && ap_write && (ap_addr == `SPF_ADDR_DATA);
  wire wr_cmd  = ap_valid && ap_write && (ap_addr == `SPF_ADDR_CMD);
  // ========================================
  // Core-side operands: pointer, data pair, instruction strobes
  reg [15:0] zptr;
  reg [15:0] data_pair;
  reg [7:0]  lpm_result;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zptr      <= 16'h0000;
      data_pair <= 16'h0000;
    end else begin
      if (wr_zptr)
        zptr <= hwdata[15:0];
      if (wr_data)
        data_pair <= hwdata[15:0];
    end
  end
  wire spm_issue = wr_cmd && (hwdata[1:0] == `SPF_CMD_SPM);
  wire lpm_issue = wr_cmd && (hwdata[1:0] == `SPF_CMD_LPM);
  // ========================================
  // Flash geometry
  function [12:0] boot_base;
    input [1:0] sz;
    begin
      case (sz)
        2'b11:   boot_base = `SPF_BOOT_128;
        2'b10:   boot_base = `SPF_BOOT_256;
        2'b01:   boot_base = `SPF_BOOT_512;
        default: boot_base = `SPF_BOOT_1024;
      endcase
    end
  endfunction
  assign boot_start = boot_base({boot_size_hi, boot_size_lo}); // R1
  wire [6:0]  page_sel  = zptr[13:7]; // R3 R5
  wire [5:0]  word_sel  = zptr[6:1]; // R4 R20
  wire [12:0] page_addr = {page_sel, 6'h00};
  wire        in_stalled_during_write_area   = (page_addr >= `SPF_STALLED_DURING_WRITE_AREA_START); // R2
  // ========================================
  // Control register and sequencer
  localparam ST_IDLE = 2'd0;
  localparam ST_ARM  = 2'd1;
  localparam ST_PROG = 2'd2;
  reg  [1:0]  state;
  reg         irq_en;
  reg         busy_flag;
  reg  [4:0]  cmd_bits;
  reg  [2:0]  win_cnt;
  reg  [2:0]  lpm_cnt;
  reg  [31:0] prog_cnt;
  reg         prog_stalled_during_write_area;
  reg         prog_is_lock;
  reg         loading;
  reg  [7:0]  lock_bits;
  reg  [6:0]  last_page;
  reg  [1:0]  last_op;
  reg  [15:0] page_buf [0:`SPF_PAGE_WORDS-1];
  reg  [63:0] buf_valid;
  wire [4:0]  wr_pat = hwdata[4:0];
  wire pat_ok = (wr_pat == `SPF_PAT_REEN) || (wr_pat == `SPF_PAT_LOCK) ||
                (wr_pat == `SPF_PAT_PGWR) || (wr_pat == `SPF_PAT_PGER) ||
                (wr_pat == `SPF_PAT_FILL); // R22
  wire arm_req = wr_csr && pat_ok && (state != ST_PROG); // R11
  wire prog_done = (state == ST_PROG) && (prog_cnt == 32'h0000_0000);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state        <= ST_IDLE;
      irq_en       <= 1'b0;
      busy_flag    <= 1'b0;
      cmd_bits     <= 5'h00;
      win_cnt      <= 3'd0;
      lpm_cnt      <= 3'd0;
      prog_cnt     <= 32'h0000_0000;
      prog_stalled_during_write_area    <= 1'b0;
      prog_is_lock <= 1'b0;
      loading      <= 1'b0;
      lock_bits    <= 8'hFF;
      lpm_result   <= 8'h00;
      buf_valid    <= 64'h0;
      last_page    <= 7'h00;
      last_op      <= 2'd0;
    end else begin
      if (wr_csr)
        irq_en <= hwdata[`SPF_B_IE];
      if (lpm_cnt != 3'd0)
        lpm_cnt <= lpm_cnt - 3'd1;
      if (lpm_issue) begin
        if (lpm_cnt != 3'd0) // R15
          lpm_result <= zptr[0] ? fuse_bits : lock_bits; // R15
        else
          lpm_result <= zptr[0] ? page_buf[word_sel][15:8] : page_buf[word_sel][7:0];
      end
      case (state)
        ST_IDLE: begin
          if (arm_req) begin
            cmd_bits <= wr_pat;
            win_cnt  <= `SPF_WINDOW_SPM; // R24
            state    <= ST_ARM;
            if (wr_pat == `SPF_PAT_LOCK)
              lpm_cnt <= `SPF_WINDOW_LPM;
            if (wr_pat == `SPF_PAT_REEN && loading) begin
              buf_valid <= 64'h0; // R12
              loading   <= 1'b0;
            end
          end
        end
        ST_ARM: begin
          if (spm_issue) begin
            case (cmd_bits)
              `SPF_PAT_FILL: begin
                page_buf[word_sel]  <= data_pair; // R20
                buf_valid[word_sel] <= 1'b1;
                loading   <= 1'b1;
                busy_flag <= 1'b0; // R9
                cmd_bits  <= 5'h00; // R21
                state     <= ST_IDLE;
              end
              `SPF_PAT_REEN: begin
                busy_flag <= 1'b0; // R9 R11
                cmd_bits  <= 5'h00;
                state     <= ST_IDLE;
              end
              `SPF_PAT_LOCK: begin
                lock_bits    <= data_pair[7:0]; // R13
                prog_is_lock <= 1'b1;
                prog_stalled_during_write_area    <= 1'b0;
                prog_cnt     <= PROG_CYCLES - 32'h0000_0001; // R23
                state        <= ST_PROG;
              end
              default: begin
                last_page    <= page_sel; // R16 R19
                last_op      <= cmd_bits[2:1];
                prog_is_lock <= 1'b0;
                prog_stalled_during_write_area    <= in_stalled_during_write_area; // R18
                if (!in_stalled_during_write_area)
                  busy_flag <= 1'b1; // R8
                if (cmd_bits == `SPF_PAT_PGWR) begin
                  buf_valid <= 64'h0;
                  loading   <= 1'b0;
                end
                prog_cnt <= PROG_CYCLES - 32'h0000_0001; // R23
                state    <= ST_PROG;
              end
            endcase
          end else if (win_cnt == 3'd1) begin
            cmd_bits <= 5'h00; // R14 R17 R19 R24
            state    <= ST_IDLE;
          end else begin
            win_cnt <= win_cnt - 3'd1;
          end
        end
        ST_PROG: begin
          if (prog_done) begin
            cmd_bits     <= 5'h00; // R14 R17 R19 R21
            prog_stalled_during_write_area    <= 1'b0;
            prog_is_lock <= 1'b0;
            state        <= ST_IDLE;
          end else begin
            prog_cnt <= prog_cnt - 32'h0000_0001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // Readable status: the enable bit is held through programming.
  wire [7:0] csr_value = {irq_en, busy_flag, 1'b0, cmd_bits}; // R6 R10 R21
  // Limitation: the array itself is not modelled; the last page and operation are reported.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ap_take && !hwrite) begin
      case (haddr)
        `SPF_ADDR_CSR:      hrdata <= {24'h00_0000, csr_value};
        `SPF_ADDR_ZPTR:     hrdata <= {16'h0000, zptr};
        `SPF_ADDR_DATA:     hrdata <= {16'h0000, data_pair};
        `SPF_ADDR_LPMDATA:  hrdata <= {24'h00_0000, lpm_result};
        `SPF_ADDR_STAT:     hrdata <= {21'h0_0000, last_op, last_page, prog_stalled_during_write_area, loading};
        `SPF_ADDR_LOCKFUSE: hrdata <= {16'h0000, fuse_bits, lock_bits};
        default:            hrdata <= 32'h0000_0000;
      endcase
    end
  end
  assign program_ready_irq = irq_en && global_irq_enable && !cmd_bits[`SPF_B_EN]; // R7
  assign core_stall    = (state == ST_PROG) && prog_stalled_during_write_area; // R18
  assign section_block = busy_flag; // R8
endmodule // spf_self_program_flash_control
`default_nettype wire

// ==== spf_self_program_flash_control_sva.sv ====
// Checker for the self-programming flash controller, bound to its top module.
// Assumes one clock domain, hclk, with asynchronous active-low hresetn.
`timescale 1ns/1ps
`default_nettype none
`include "spf_consts.vh"
// ========================================
// Checker
module spf_self_program_flash_control_sva #(
  parameter [31:0] PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Status
  input wire logic        boot_size_hi,
  input wire logic        boot_size_lo,
  input wire logic        global_irq_enable,
  input wire logic        program_ready_irq,
  input wire logic        core_stall,
  input wire logic [12:0] boot_start,
  input wire logic        section_block
);
  logic        rd_csr;
  logic [31:0] stall_cnt;
  // Marks the data phase of a control register read so read data is judged only there.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_csr    <= 1'b0;
      stall_cnt <= '0;
    end else begin
      if (hready) rd_csr <= hsel && htrans[1] && !hwrite && haddr == `SPF_ADDR_CSR;
      stall_cnt <= core_stall ? stall_cnt + 32'd1 : '0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_stall_start; $rose(core_stall); endsequence
  sequence s_busy_start; $rose(section_block); endsequence
  AST_BOOT: assert property (
    boot_start == (boot_size_hi ? (boot_size_lo ? 13'h1F80 : 13'h1F00)
                                : (boot_size_lo ? 13'h1E00 : 13'h1C00)))
    else $error("boot start mismatch");
  AST_IRQ_GATE: assert property (!global_irq_enable |-> !program_ready_irq)
    else $error("irq without global enable");
  AST_RES_BIT: assert property (rd_csr |-> hrdata[5] == 1'b0)
    else $error("reserved bit read as one");
  AST_CSR_WIDTH: assert property (rd_csr |-> hrdata[31:8] == 24'h0)
    else $error("csr read wider than eight bits");
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  AST_STALL_HOLD: assert property (s_stall_start |-> core_stall [*8])
    else $error("stall dropped early");
  AST_STALL_LEN: assert property (
    $fell(core_stall) |-> stall_cnt + 2 >= PROG_CYCLES && stall_cnt <= PROG_CYCLES + 2)
    else $error("stall length off");
  AST_STALLED_DURING_WRITE_AREA_NO_BUSY: assert property (s_stall_start |-> !$rose(section_block))
    else $error("busy set by stalling operation");
  AST_RWW_NO_STALL: assert property (s_busy_start |-> !core_stall)
    else $error("stall on readable area operation");
  AST_BUSY_HOLD: assert property (s_busy_start |=> section_block [*8])
    else $error("busy cleared during programming");
endmodule // spf_self_program_flash_control_sva
`default_nettype wire

// ==== spf_core_model.sv ====
// Core model: issues single-word AHB-Lite transfers on request of the bench.
// Assumes hready is the slave's hreadyout; read data is taken at the data edge.
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Bus master
module spf_core_model (
  // Clock and answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Request
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = '0;
  end
  // Released lines show the inverse so stale values never pass for answers.
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    haddr  <= ~a;
    hwdata <= w ? d : ~d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule // spf_core_model
`default_nettype wire

// ==== spf_self_program_flash_control_tb.sv ====
// Bench: register-level sequences of the boot loader against the controller.
// Assumes the controller, its constants header and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "spf_consts.vh"
// ========================================
// Bench top
module spf_self_program_flash_control_tb;
  localparam int PC = 20;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, program_ready_irq, core_stall, section_block;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [12:0] boot_start;
  logic [12:0] bt [4] = '{`SPF_BOOT_1024, `SPF_BOOT_512, `SPF_BOOT_256, `SPF_BOOT_128};
  logic        boot_size_hi = 1'b0;
  logic        boot_size_lo = 1'b0;
  logic        global_irq_enable = 1'b0;
  logic [7:0]  fuse_bits = 8'h5A;
  int          miscompares = 0;
  int          n_checks = 0;
  always #50 hclk = ~hclk;
  spf_self_program_flash_control #(.PROG_CYCLES(PC)) spf_self_program_flash_control_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .boot_size_hi, .boot_size_lo, .global_irq_enable, .fuse_bits,
    .program_ready_irq, .core_stall, .boot_start, .section_block);
  spf_core_model spf_core_model_inst (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata);
  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic w(input logic [31:0] a, d);
    spf_core_model_inst.xfer(1'b1, a, d, rv);
  endtask
  task automatic r(input logic [31:0] a, e, input string what);
    spf_core_model_inst.xfer(1'b0, a, 32'h0, rv);
    chk(rv, e, what);
  endtask
  // Writes a pattern and, when cmd is not zero, the store or load that it arms.
  task automatic csr(input logic [7:0] v, input logic [31:0] cmd);
    w(`SPF_ADDR_CSR, {24'h0, v});
    if (cmd != 0) w(`SPF_ADDR_CMD, cmd);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(100 * 3000);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    r(`SPF_ADDR_CSR, 32'h0, "csr reset");
    for (int i = 0; i < 4; i++) begin
      {boot_size_hi, boot_size_lo} <= i[1:0];
      @(posedge hclk);
      #1 chk({19'h0, boot_start}, {19'h0, bt[i]}, "boot start");
    end
    $display("test reset and boot size done");
    csr(8'hA7, 0);
    r(`SPF_ADDR_CSR, 32'h80, "bad pattern");
    global_irq_enable <= 1'b1;
    @(posedge hclk);
    #1 chk(program_ready_irq, 1, "irq idle");
    csr(8'h81, 0);
    #1 chk(program_ready_irq, 0, "irq armed");
    foreach (bt[i]) begin
      if (i > 0) csr(8'h80 | (8'h11 >> (i - 1) & 8'h1F | 8'h01), 0);
      repeat (6) @(posedge hclk);
      r(`SPF_ADDR_CSR, 32'h80, "window expiry");
    end
    csr(8'h83, 0);
    repeat (6) @(posedge hclk);
    r(`SPF_ADDR_CSR, 32'h80, "erase window expiry");
    global_irq_enable <= 1'b0;
    csr(8'h00, 0);
    $display("test patterns and window done");
    w(`SPF_ADDR_ZPTR, 32'h0000_C080);
    csr(8'h03, 32'h1);
    r(`SPF_ADDR_CSR, 32'h43, "erase running");
    chk(core_stall, 0, "no stall");
    csr(8'h11, 32'h1);
    r(`SPF_ADDR_CSR, 32'h43, "reenable refused");
    repeat (PC + 4) @(posedge hclk);
    r(`SPF_ADDR_CSR, 32'h40, "erase done");
    w(`SPF_ADDR_ZPTR, 32'h0000_0086);
    w(`SPF_ADDR_DATA, 32'h0000_1234);
    csr(8'h01, 32'h1);
    r(`SPF_ADDR_CSR, 32'h00, "load clears busy");
    r(`SPF_ADDR_STAT, 32'h0000_0205, "buffer loading");
    csr(8'h11, 0);
    r(`SPF_ADDR_STAT, 32'h0000_0204, "load aborted");
    w(`SPF_ADDR_ZPTR, 32'h0000_0080);
    csr(8'h05, 32'h1);
    r(`SPF_ADDR_CSR, 32'h45, "write running");
    repeat (PC + 4) @(posedge hclk);
    csr(8'h11, 32'h1);
    r(`SPF_ADDR_CSR, 32'h00, "reenabled");
    $display("test readable area done");
    w(`SPF_ADDR_ZPTR, 32'h0000_3800);
    csr(8'h03, 32'h1);
    #1 chk(core_stall, 1, "stall");
    chk(section_block, 0, "no busy");
    repeat (PC + 4) @(posedge hclk);
    chk(core_stall, 0, "stall end");
    w(`SPF_ADDR_DATA, 32'h0000_FFFC);
    csr(8'h09, 32'h1);
    repeat (PC + 4) @(posedge hclk);
    r(`SPF_ADDR_CSR, 32'h00, "lock done");
    for (int z = 0; z < 2; z++) begin
      w(`SPF_ADDR_ZPTR, z);
      csr(8'h09, 32'h2);
      r(`SPF_ADDR_LPMDATA, z ? 32'h5A : 32'hFC, "lock or fuse read");
    end
    $display("test stalled area and lock done");
    stop_test();
  end
endmodule // spf_self_program_flash_control_tb
bind spf_self_program_flash_control spf_self_program_flash_control_sva #(
  .PROG_CYCLES(PROG_CYCLES)) spf_sva_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .boot_size_hi, .boot_size_lo, .global_irq_enable,
  .program_ready_irq, .core_stall, .boot_start, .section_block);
`default_nettype wire
